// ===== design/paes_defines.svh
`ifndef PAES_DEFINES_SVH
`define PAES_DEFINES_SVH

// Register indices; byte address is four times the index
`define PAES_IDX_CFG        10'h0D8
`define PAES_IDX_NP         10'h0DE
`define PAES_IDX_ADV        10'h0E0
`define PAES_IDX_WEC        10'h0E2

// Received next page fields
`define PAES_NP_MORE        15
`define PAES_NP_ACK         14
`define PAES_NP_MSG         13
`define PAES_NP_COMPLY_ACKNOWLEDGE        12
`define PAES_NP_TOG         11
`define PAES_NP_CODE_HI     10

// Configuration and advertisement fields
`define PAES_CFG_COPPER     6
`define PAES_ADV_LP_HI      14
`define PAES_ADV_LP_LO      9
`define PAES_ADV_LOC_HI     6
`define PAES_ADV_LOC_LO     2
`define PAES_ADV_100TX      1

// Reset values
`define PAES_RST_COPPER     1'b1
`define PAES_RST_ADV100     1'b1
`define PAES_RST_NP         16'h0000
`define PAES_RST_WEC        16'h0000

// Sequencing constants
`define PAES_FLP_CONSIST    2'h3
`define PAES_WEC_ONE        16'h0001
`define PAES_WEC_FULL       16'hFFFF
`define PAES_WCNT_W         10
`define PAES_WAKE_NS        20500
`define PAES_CLK_NS         40

`endif

// ===== design/paes_pkg.sv
package paes_pkg;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } paes_page_t;

   typedef struct packed {
      logic       valid;
      logic [5:0] bits;
   } paes_lpadv_t;

   typedef struct packed {
      logic [15:0] np;
      logic [5:0]  lp_adv;
      logic        adv100;
      logic        adv_out;
      logic        copper;
      logic        tog_prev;
      logic        tog_err;
      logic [15:0] flp_last;
      logic [1:0]  flp_cnt;
      logic        ack;
      logic [9:0]  wake_cnt;
      logic        wake_done;
      logic [15:0] wec;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } paes_state_t;

endpackage

// ===== design/paes_regs.sv
`timescale 1ns/1ps
`include "paes_defines.svh"

module paes_regs
   import paes_pkg::*;
#(
   parameter int WAKE_LIMIT_NS = `PAES_WAKE_NS,
   parameter int CLK_NS        = `PAES_CLK_NS
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire paes_page_t  np_in,
   input  wire paes_page_t  base_in,
   input  wire paes_page_t  flp_in,
   input  wire paes_lpadv_t lp_eee_in,
   input  wire logic        lpi_waking,
   output logic             copper_mode,
   output logic             eee_adv_100tx,
   output logic             tx_ack,
   output logic             toggle_err
);

   localparam int WAKE_CYC_I = (WAKE_LIMIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [`PAES_WCNT_W-1:0] WAKE_CYC =
      `PAES_WCNT_W'(WAKE_CYC_I);

   localparam paes_state_t ST_RST = '{
      default : '0,
      np      : `PAES_RST_NP,
      wec     : `PAES_RST_WEC,
      copper  : `PAES_RST_COPPER,
      adv100  : `PAES_RST_ADV100,
      adv_out : `PAES_RST_ADV100 & `PAES_RST_COPPER
   };

   paes_state_t s_q;
   paes_state_t s_d;
   logic        acc;
   logic        done;
   logic        rd_wec;
   logic        wake_rise;
   logic [15:0] flp_masked;
   logic [15:0] adv_view;

   // Address match against a register index
   function automatic logic hit(input logic [11:0] a,
                                input logic [9:0]  idx);
      hit = (a == {idx, 2'b00});
   endfunction

   assign acc        = psel & penable & ~s_q.pready;
   assign done       = psel & penable & s_q.pready;
   assign rd_wec     = acc & ~pwrite & hit(paddr, `PAES_IDX_WEC);
   assign flp_masked = flp_in.word & ~(16'h0001 << `PAES_NP_ACK);
   assign adv_view   = {1'b0, s_q.lp_adv, 2'b00, 5'b00000,
                        s_q.adv100, 1'b0};

   always_comb begin
      s_d = s_q;
      wake_rise = 1'b0;

      // Bus slave: one wait state, data and error taken with pready
      s_d.pready = acc;
      if (acc) begin
         s_d.pslverr = ~(hit(paddr, `PAES_IDX_CFG) |
                         hit(paddr, `PAES_IDX_NP)  |
                         hit(paddr, `PAES_IDX_ADV) |
                         hit(paddr, `PAES_IDX_WEC));
         s_d.prdata = '0;
         if (!pwrite) begin
            if (hit(paddr, `PAES_IDX_CFG))
               s_d.prdata[`PAES_CFG_COPPER] = s_q.copper;
            if (hit(paddr, `PAES_IDX_NP))
               s_d.prdata[15:0] = s_q.np;
            if (hit(paddr, `PAES_IDX_ADV))
               s_d.prdata[15:0] = adv_view;
            if (rd_wec)
               s_d.prdata[15:0] = s_q.wec;
         end
      end else begin
         s_d.pslverr = 1'b0;
      end

      // Writes land on the completing edge
      if (done && pwrite) begin
         if (hit(paddr, `PAES_IDX_CFG))
            s_d.copper = pwdata[`PAES_CFG_COPPER];
         if (hit(paddr, `PAES_IDX_ADV))
            s_d.adv100 = pwdata[`PAES_ADV_100TX];
      end
      s_d.adv_out = s_d.adv100 & s_d.copper;

      // Base page seeds toggle tracking
      if (base_in.valid) begin
         s_d.tog_prev = base_in.word[`PAES_NP_TOG];
         s_d.tog_err  = 1'b0;
      end

      // Partner next page captured whole, fields in place
      if (np_in.valid) begin
         s_d.np[`PAES_NP_MORE] = np_in.word[`PAES_NP_MORE];
         s_d.np[`PAES_NP_ACK]  = np_in.word[`PAES_NP_ACK];
         s_d.np[`PAES_NP_MSG]  = np_in.word[`PAES_NP_MSG];
         s_d.np[`PAES_NP_COMPLY_ACKNOWLEDGE] = np_in.word[`PAES_NP_COMPLY_ACKNOWLEDGE];
         s_d.np[`PAES_NP_TOG]  = np_in.word[`PAES_NP_TOG];
         s_d.np[`PAES_NP_CODE_HI:0] =
            np_in.word[`PAES_NP_CODE_HI:0];
         if (np_in.word[`PAES_NP_TOG] == s_q.tog_prev)
            s_d.tog_err = 1'b1;
         s_d.tog_prev = np_in.word[`PAES_NP_TOG];
      end

      // Consistent burst counting, ack bit masked
      if (flp_in.valid) begin
         if (s_q.flp_cnt != 2'h0 && flp_masked == s_q.flp_last) begin
            if (s_q.flp_cnt != `PAES_FLP_CONSIST)
               s_d.flp_cnt = s_q.flp_cnt + 2'h1;
         end else begin
            s_d.flp_cnt = 2'h1;
         end
         s_d.flp_last = flp_masked;
      end
      s_d.ack = (s_d.flp_cnt == `PAES_FLP_CONSIST);

      // Partner low-power abilities, copper only
      if (!s_q.copper)
         s_d.lp_adv = '0;
      else if (lp_eee_in.valid)
         s_d.lp_adv = lp_eee_in.bits;

      // Wake timer against the limit
      if (lpi_waking && s_q.copper) begin
         if (s_q.wake_cnt != WAKE_CYC)
            s_d.wake_cnt = s_q.wake_cnt + `PAES_WCNT_W'(1);
      end else begin
         s_d.wake_cnt = '0;
      end
      s_d.wake_done = lpi_waking & s_q.copper &
                      (s_q.wake_cnt == WAKE_CYC);
      wake_rise = s_d.wake_done & ~s_q.wake_done;

      // Saturating clear-on-read counter; a new event survives a clear
      if (rd_wec)
         s_d.wec = wake_rise ? `PAES_WEC_ONE : `PAES_RST_WEC;
      else if (wake_rise && s_q.wec != `PAES_WEC_FULL)
         s_d.wec = s_q.wec + `PAES_WEC_ONE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata        = s_q.prdata;
   assign pready        = s_q.pready;
   assign pslverr       = s_q.pslverr;
   assign copper_mode   = s_q.copper;
   assign eee_adv_100tx = s_q.adv_out;
   assign tx_ack        = s_q.ack;
   assign toggle_err    = s_q.tog_err;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   np_capture_a: assert property (
      np_in.valid |=> s_q.np == $past(np_in.word))
      else $error("next page not captured");

   np_read_a: assert property (
      acc && !pwrite && hit(paddr, `PAES_IDX_NP)
      |=> pready && prdata[15:0] == $past(s_q.np))
      else $error("next page read mismatch");

   ack_burst_a: assert property (
      $rose(tx_ack) |-> $past(flp_in.valid) &&
                        s_q.flp_cnt == `PAES_FLP_CONSIST)
      else $error("ack without three bursts");

   ack_drop_a: assert property (
      flp_in.valid && flp_masked != s_q.flp_last |=> !tx_ack)
      else $error("ack kept after broken burst");

   ack_hold_a: assert property (
      !flp_in.valid |=> $stable(tx_ack))
      else $error("ack moved without a burst");

   toggle_chk_a: assert property (
      np_in.valid && !base_in.valid &&
      np_in.word[`PAES_NP_TOG] == s_q.tog_prev |=> toggle_err)
      else $error("toggle repeat not flagged");

   first_toggle_a: assert property (
      base_in.valid && !np_in.valid
      |=> s_q.tog_prev == $past(base_in.word[`PAES_NP_TOG]) && !toggle_err)
      else $error("base toggle not seeded");

   np_flags_a: assert property (
      np_in.valid |=> s_q.np[`PAES_NP_MORE:`PAES_NP_COMPLY_ACKNOWLEDGE] ==
                      $past(np_in.word[`PAES_NP_MORE:`PAES_NP_COMPLY_ACKNOWLEDGE]))
      else $error("next page flags misplaced");

   np_hold_a: assert property (
      !np_in.valid |=> $stable(s_q.np))
      else $error("next page changed without a page");

   np_readonly_a: assert property (
      done && pwrite && hit(paddr, `PAES_IDX_NP) && !np_in.valid
      |=> $stable(s_q.np))
      else $error("next page written by software");

   toggle_keep_a: assert property (
      toggle_err && !base_in.valid |=> toggle_err)
      else $error("toggle error lost");

   adv_read_a: assert property (
      acc && !pwrite && hit(paddr, `PAES_IDX_ADV)
      |=> prdata[`PAES_ADV_LOC_HI:`PAES_ADV_LOC_LO] == '0 &&
          prdata[`PAES_ADV_LP_HI:`PAES_ADV_LP_LO] == $past(s_q.lp_adv))
      else $error("advertisement read wrong");

   adv_write_a: assert property (
      done && pwrite && hit(paddr, `PAES_IDX_ADV)
      |=> s_q.adv100 == $past(pwdata[`PAES_ADV_100TX]))
      else $error("advertisement write lost");

   adv_hold_a: assert property (
      !(done && pwrite && hit(paddr, `PAES_IDX_ADV))
      |=> $stable(s_q.adv100))
      else $error("advertisement bit moved");

   lp_capture_a: assert property (
      copper_mode && lp_eee_in.valid
      |=> s_q.lp_adv == $past(lp_eee_in.bits))
      else $error("partner abilities not captured");

   lp_hold_a: assert property (
      copper_mode && !lp_eee_in.valid |=> $stable(s_q.lp_adv))
      else $error("partner abilities moved");

   fiber_off_a: assert property (
      !copper_mode
      |-> !eee_adv_100tx ##1 s_q.lp_adv == 6'h00)
      else $error("low-power active in fiber");

   adv_out_a: assert property (
      eee_adv_100tx |-> copper_mode && s_q.adv100)
      else $error("advert out without copper");

   fiber_wake_a: assert property (
      !copper_mode |=> s_q.wake_cnt == '0 && !s_q.wake_done)
      else $error("wake timer ran in fiber");

   fiber_count_a: assert property (
      !copper_mode && !rd_wec |=> $stable(s_q.wec))
      else $error("wake error counted in fiber");

   cfg_write_a: assert property (
      done && pwrite && hit(paddr, `PAES_IDX_CFG)
      |=> copper_mode == $past(pwdata[`PAES_CFG_COPPER]))
      else $error("mode write lost");

   cfg_hold_a: assert property (
      !(done && pwrite && hit(paddr, `PAES_IDX_CFG))
      |=> $stable(copper_mode))
      else $error("mode moved without a write");

   cfg_read_a: assert property (
      acc && !pwrite && hit(paddr, `PAES_IDX_CFG)
      |=> prdata[`PAES_CFG_COPPER] == $past(s_q.copper))
      else $error("mode read wrong");

   wake_limit_a: assert property (
      $rose(s_q.wake_done) |-> $past(s_q.wake_cnt) == WAKE_CYC)
      else $error("wake done at wrong count");

   wake_restart_a: assert property (
      !lpi_waking |=> s_q.wake_cnt == '0 && !s_q.wake_done)
      else $error("wake timer not restarted");

   wake_done_a: assert property (
      s_q.wake_done |-> $past(lpi_waking) && $past(copper_mode))
      else $error("wake done without waking");

   wec_inc_a: assert property (
      wake_rise && !rd_wec && s_q.wec != `PAES_WEC_FULL
      |=> s_q.wec == $past(s_q.wec) + `PAES_WEC_ONE)
      else $error("wake error not counted");

   wec_quiet_a: assert property (
      !wake_rise && !rd_wec |=> $stable(s_q.wec))
      else $error("wake error counted without event");

   wec_sat_a: assert property (
      s_q.wec == `PAES_WEC_FULL && !rd_wec |=> s_q.wec == `PAES_WEC_FULL)
      else $error("counter wrapped");

   wec_clear_a: assert property (
      rd_wec |=> prdata[15:0] == $past(s_q.wec) && s_q.wec <= `PAES_WEC_ONE)
      else $error("read did not clear counter");

   wec_race_a: assert property (
      rd_wec && wake_rise |=> s_q.wec == `PAES_WEC_ONE)
      else $error("event lost on clearing read");

   np_seen_c: cover property (np_in.valid ##1 acc && !pwrite);
   ack_seen_c: cover property ($rose(tx_ack));
   wec_sat_c: cover property (s_q.wec == `PAES_WEC_FULL);
   wec_race_c: cover property (rd_wec && wake_rise);
   fiber_wake_c: cover property (!copper_mode && lpi_waking);

endmodule // paes_regs

// ===== bench/paes_partner.sv
`timescale 1ns/1ps
module paes_partner
   import paes_pkg::*;
(
   input  wire logic   pclk,
   output paes_page_t  np_o,
   output paes_page_t  base_o,
   output paes_page_t  flp_o,
   output paes_lpadv_t lp_o,
   output logic        waking_o
);
   logic tog = 1'b0;

   initial begin
      np_o = '0;
      base_o = '0;
      flp_o = '0;
      lp_o = '0;
      waking_o = 1'b0;
   end

   // One-cycle strobe; released words keep changing
   task automatic pulse(input int k, input logic [15:0] w);
      @(posedge pclk);
      case (k)
         0: np_o <= '{1'b1, w};
         1: base_o <= '{1'b1, w};
         2: flp_o <= '{1'b1, w};
         default: lp_o <= '{1'b1, w[5:0]};
      endcase
      @(posedge pclk);
      np_o <= '{1'b0, ~np_o.word};
      base_o <= '{1'b0, ~base_o.word};
      flp_o <= '{1'b0, ~flp_o.word};
      lp_o <= '{1'b0, ~lp_o.bits};
   endtask

   task automatic base_page(input logic [15:0] w);
      tog = w[11];
      pulse(1, w);
   endtask

   // Bad page repeats the previous toggle on purpose
   task automatic next_page(input logic [15:0] w, input logic bad);
      w[11] = bad ? tog : ~tog;
      tog = w[11];
      pulse(0, w);
   endtask

   task automatic wake(input int n);
      @(posedge pclk);
      waking_o <= 1'b1;
      repeat (n) @(posedge pclk);
      waking_o <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
endmodule // paes_partner

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench
   import paes_pkg::*;
;
   localparam logic [11:0] A_CFG = 12'h360;
   localparam logic [11:0] A_NP  = 12'h378;
   localparam logic [11:0] A_ADV = 12'h380;
   localparam logic [11:0] A_WEC = 12'h388;
   localparam logic [11:0] A_LPC = 12'h3CC;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready, pslverr, copper_mode, eee_adv_100tx;
   logic        tx_ack, toggle_err, lpi_waking;
   paes_page_t  np_in, base_in, flp_in;
   paes_lpadv_t lp_eee_in;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          cyc = 0;

   always #20 pclk = ~pclk;

   paes_regs #(.WAKE_LIMIT_NS(400)) paes_regs_i (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .np_in, .base_in, .flp_in,
      .lp_eee_in, .lpi_waking, .copper_mode, .eee_adv_100tx,
      .tx_ack, .toggle_err);

   paes_partner paes_partner_i (.pclk, .np_o(np_in), .base_o(base_in),
      .flp_o(flp_in), .lp_o(lp_eee_in), .waking_o(lpi_waking));

   task automatic test_done();
      $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Returns {pslverr, prdata}
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [32:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      logic [32:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [32:0] r;
      apb(1'b1, a, d, r);
   endtask

   // Copper, 100TX advert, ack, toggle error
   task automatic outs(input logic [3:0] exp);
      @(negedge pclk);
      chk({29'h0, copper_mode, eee_adv_100tx, tx_ack, toggle_err},
          {29'h0, exp});
   endtask

   task automatic t_reset();
      outs(4'hC);
      rd(A_CFG, 33'h040);
      rd(A_NP, 33'h0);
      rd(A_ADV, 33'h002);
      rd(A_WEC, 33'h0);
      rd(12'h3FC, 33'h1_0000_0000);
   endtask

   task automatic t_page();
      paes_partner_i.base_page(16'h0800);
      paes_partner_i.next_page(16'hF0A5, 1'b0);
      rd(A_NP, 33'h0F0A5);
      outs(4'hC);
      paes_partner_i.next_page(16'h2BCD, 1'b0);
      rd(A_NP, 33'h02BCD);
      wr(A_NP, 32'hFFFF);
      rd(A_NP, 33'h02BCD);
      paes_partner_i.next_page(16'h4000, 1'b1);
      outs(4'hD);
      paes_partner_i.base_page(16'h0000);
      outs(4'hC);
   endtask

   // Ack bit differs between bursts and must be ignored
   task automatic t_flp();
      paes_partner_i.pulse(2, 16'h41E1);
      paes_partner_i.pulse(2, 16'h01E1);
      outs(4'hC);
      paes_partner_i.pulse(2, 16'h41E1);
      outs(4'hE);
      paes_partner_i.pulse(2, 16'h0021);
      outs(4'hC);
   endtask

   task automatic t_adv();
      paes_partner_i.pulse(3, 16'h002B);
      rd(A_ADV, 33'h05602);
      wr(A_ADV, 32'hFFFF);
      rd(A_ADV, 33'h05602);
      wr(A_ADV, 32'h0);
      rd(A_ADV, 33'h05600);
      outs(4'h8);
      wr(A_ADV, 32'h2);
      outs(4'hC);
   endtask

   // Low-power disable goes to a control register outside this block
   task automatic t_lpc();
      logic [32:0] r;
      apb(1'b1, A_LPC, 32'h0, r);
      chk(r, 33'h1_0000_0000);
      rd(A_ADV, 33'h05602);
   endtask

   task automatic t_wec();
      paes_partner_i.wake(20);
      paes_partner_i.wake(20);
      rd(A_WEC, 33'h2);
      rd(A_WEC, 33'h0);
      paes_partner_i.wake(5);
      rd(A_WEC, 33'h0);
   endtask

   task automatic t_fiber();
      wr(A_CFG, 32'h0);
      outs(4'h0);
      paes_partner_i.pulse(3, 16'h003F);
      rd(A_ADV, 33'h002);
      paes_partner_i.wake(20);
      rd(A_WEC, 33'h0);
      wr(A_CFG, 32'h40);
      outs(4'hC);
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_page();
      t_flp();
      t_adv();
      t_lpc();
      t_wec();
      t_fiber();
      test_done();
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         test_done();
      end
   end
endmodule // testbench
